// File: hw/ciq_top.sv
// Control input qualifier of a loop detector: glitch filter, dwell and
// same-direction lockout on the active-low control inputs, delay/extension
// gating per channel, and an AC power interruption supervisor.
// Assumes all inputs are synchronous to clk and that the pins have pull-ups,
// so an open input arrives here as a high level.
`include "ciq_consts.svh"

module ciq_top #(
    parameter int TICK_CYCLES = `CIQ_TICK_CYCLES
) (
    input wire logic clk,
    input wire logic rstn,
    input wire ciq_pkg::ciq_ctl_t [`CIQ_NCH-1:0] ctl_in,
    input wire logic ac_ok,
    output ciq_pkg::ciq_qual_t [`CIQ_NCH-1:0] qual_out,
    output logic [`CIQ_NCH-1:0] de_active,
    output logic startup_busy,
    output logic restart_pulse,
    output logic [`CIQ_EVT_W-1:0] interruption_count
);

    localparam int NIN = 2 * `CIQ_NCH;

    ////////////////////////////////////////////////////////////////////////
    // Millisecond tick.

    logic [`CIQ_TICK_W-1:0] tick_cnt_r;
    logic tick_r;

    always_ff @(posedge clk) begin
        if (!rstn) begin
            tick_cnt_r <= '0;
            tick_r <= 1'b0;
        end else if (tick_cnt_r == `CIQ_TICK_W'(TICK_CYCLES - 1)) begin
            tick_cnt_r <= '0;
            tick_r <= 1'b1;
        end else begin
            tick_cnt_r <= tick_cnt_r + `CIQ_TICK_W'(1);
            tick_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Input qualification, one filter per control pin.

    logic [NIN-1:0] raw_act;
    logic [NIN-1:0] qual_act_r;

    genvar gc;
    generate
        for (gc = 0; gc < `CIQ_NCH; gc = gc + 1) begin : g_map
            // A low pin is the asserted condition.
            assign raw_act[gc] = ~ctl_in[gc].enable_n;
            assign raw_act[`CIQ_NCH + gc] = ~ctl_in[gc].inhibit_n;
        end
    endgenerate

    genvar gi;
    generate
        for (gi = 0; gi < NIN; gi = gi + 1) begin : g_filt
            logic [`CIQ_CNT_W-1:0] dwell_r;
            logic [`CIQ_CNT_W-1:0] lock_on_r;
            logic [`CIQ_CNT_W-1:0] lock_off_r;
            logic differs;
            logic lock_busy;
            logic accept;

            assign differs = raw_act[gi] ^ qual_act_r[gi];
            assign lock_busy = raw_act[gi] ? (lock_on_r != '0) : (lock_off_r != '0);
            // A change is taken only after the full dwell and outside the
            // lockout of its own direction; a held level that meets a
            // running lockout is taken as soon as the lockout ends.
            assign accept = differs && (dwell_r == `CIQ_DWELL_MS) && !lock_busy;

            // Any return to the qualified level restarts the dwell count, so
            // a short pulse never reaches the threshold.
            always_ff @(posedge clk) begin
                if (!rstn) begin
                    dwell_r <= '0;
                end else if (!differs || accept) begin
                    dwell_r <= '0;
                end else if (tick_r && (dwell_r != `CIQ_DWELL_MS)) begin
                    dwell_r <= dwell_r + `CIQ_CNT_W'(1);
                end
            end

            // Reset leaves every input deasserted, as an open pin would read.
            always_ff @(posedge clk) begin
                if (!rstn) begin
                    qual_act_r[gi] <= 1'b0;
                end else if (accept) begin
                    qual_act_r[gi] <= raw_act[gi];
                end
            end

            // Lockouts run down on the tick; 15 ms dwell plus 50 ms lockout
            // stays well inside the 136 ms window.
            always_ff @(posedge clk) begin
                if (!rstn) begin
                    lock_on_r <= '0;
                    lock_off_r <= '0;
                end else begin
                    if (accept && raw_act[gi]) begin
                        lock_on_r <= `CIQ_LOCKOUT_MS;
                    end else if (tick_r && (lock_on_r != '0)) begin
                        lock_on_r <= lock_on_r - `CIQ_CNT_W'(1);
                    end
                    if (accept && !raw_act[gi]) begin
                        lock_off_r <= `CIQ_LOCKOUT_MS;
                    end else if (tick_r && (lock_off_r != '0)) begin
                        lock_off_r <= lock_off_r - `CIQ_CNT_W'(1);
                    end
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Power interruption supervisor.

    ciq_pkg::ciq_pwr_state_t pwr_state_r;
    logic [`CIQ_LOSS_W-1:0] loss_ms_r;
    logic [`CIQ_GAP_W-1:0] gap_ms_r;
    logic [`CIQ_START_W-1:0] start_ms_r;
    logic short_gap_r;
    logic long_loss;
    logic start_done;

    assign long_loss = loss_ms_r >= `CIQ_LONG_LOSS_TICKS;
    assign start_done = start_ms_r == `CIQ_STARTUP_MS;

    always_ff @(posedge clk) begin
        if (!rstn) begin
            pwr_state_r <= ciq_pkg::CIQ_PWR_START;
        end else begin
            case (pwr_state_r)
                ciq_pkg::CIQ_PWR_START: begin
                    if (start_done && ac_ok) begin
                        pwr_state_r <= ciq_pkg::CIQ_PWR_RUN;
                    end
                end
                ciq_pkg::CIQ_PWR_RUN: begin
                    if (!ac_ok) begin
                        pwr_state_r <= ciq_pkg::CIQ_PWR_LOSS;
                    end
                end
                ciq_pkg::CIQ_PWR_LOSS: begin
                    if (ac_ok && (long_loss || short_gap_r)) begin
                        pwr_state_r <= ciq_pkg::CIQ_PWR_START;
                    end else if (ac_ok) begin
                        pwr_state_r <= ciq_pkg::CIQ_PWR_RUN;
                    end
                end
                default: begin
                    pwr_state_r <= ciq_pkg::CIQ_PWR_START;
                end
            endcase
        end
    end

    // Start-up timer, restarted whenever power drops during start-up.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            start_ms_r <= '0;
        end else if (pwr_state_r != ciq_pkg::CIQ_PWR_START || !ac_ok) begin
            start_ms_r <= '0;
        end else if (tick_r && !start_done) begin
            start_ms_r <= start_ms_r + `CIQ_START_W'(1);
        end
    end

    // Length of the current loss in ticks, saturating at the limit.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            loss_ms_r <= '0;
        end else if (pwr_state_r != ciq_pkg::CIQ_PWR_LOSS) begin
            loss_ms_r <= '0;
        end else if (tick_r && !long_loss) begin
            loss_ms_r <= loss_ms_r + `CIQ_LOSS_W'(1);
        end
    end

    // Time since power came back; start-up counts as a long restoration.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            gap_ms_r <= `CIQ_GAP_MAX;
        end else if (pwr_state_r == ciq_pkg::CIQ_PWR_START) begin
            gap_ms_r <= `CIQ_GAP_MAX;
        end else if (pwr_state_r == ciq_pkg::CIQ_PWR_LOSS) begin
            gap_ms_r <= '0;
        end else if (tick_r && (gap_ms_r != `CIQ_GAP_MAX)) begin
            gap_ms_r <= gap_ms_r + `CIQ_GAP_W'(1);
        end
    end

    // A loss that follows too short a restoration is not covered by the
    // ride-through promise, and the unit restarts after it.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            short_gap_r <= 1'b0;
        end else if (pwr_state_r == ciq_pkg::CIQ_PWR_RUN && !ac_ok) begin
            short_gap_r <= gap_ms_r < `CIQ_RIDE_GAP_MS;
        end
    end

    // Losses joined by restorations shorter than the separation time count
    // as one interruption.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            interruption_count <= '0;
        end else if (pwr_state_r == ciq_pkg::CIQ_PWR_RUN && !ac_ok &&
                     gap_ms_r >= `CIQ_SEPARATE_GAP_MS &&
                     interruption_count != '1) begin
            interruption_count <= interruption_count + `CIQ_EVT_W'(1);
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            restart_pulse <= 1'b0;
            startup_busy <= 1'b1;
        end else begin
            restart_pulse <= (pwr_state_r == ciq_pkg::CIQ_PWR_LOSS) && ac_ok &&
                             (long_loss || short_gap_r);
            startup_busy <= pwr_state_r == ciq_pkg::CIQ_PWR_START;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Delay/extension gating and qualified outputs.

    genvar gd;
    generate
        for (gd = 0; gd < `CIQ_NCH; gd = gd + 1) begin : g_de
            // Inhibit overrides enable; nothing is active during start-up.
            always_ff @(posedge clk) begin
                if (!rstn) begin
                    de_active[gd] <= 1'b0;
                end else begin
                    de_active[gd] <= qual_act_r[gd] &&
                                     !qual_act_r[`CIQ_NCH + gd] &&
                                     (pwr_state_r != ciq_pkg::CIQ_PWR_START);
                end
            end

            always_ff @(posedge clk) begin
                if (!rstn) begin
                    qual_out[gd] <= '0;
                end else begin
                    qual_out[gd].enable <= qual_act_r[gd];
                    qual_out[gd].inhibit <= qual_act_r[`CIQ_NCH + gd];
                end
            end
        end
    endgenerate

endmodule

// File: pkg/ciq_consts.svh
// Timing counts and sizes for the control input qualifier.
// Assumes a 250 MHz core clock and a millisecond tick built from it.
`ifndef CIQ_CONSTS_SVH
`define CIQ_CONSTS_SVH

`define CIQ_NCH 4
`define CIQ_CLK_PERIOD_NS 4
`define CIQ_TICK_PERIOD_NS 1000000
`define CIQ_TICK_CYCLES (`CIQ_TICK_PERIOD_NS / `CIQ_CLK_PERIOD_NS)
`define CIQ_TICK_W 18

// Filter times in milliseconds, one tick per millisecond.
`define CIQ_DWELL_MS 6'h0F
`define CIQ_LOCKOUT_MS 6'h32
`define CIQ_CNT_W 6

// Power supervisor times in milliseconds.
`define CIQ_SHORT_LOSS_MS 5'h14
`define CIQ_LONG_LOSS_TICKS 5'h15
`define CIQ_LOSS_W 5
`define CIQ_RIDE_GAP_MS 11'h12B
`define CIQ_SEPARATE_GAP_MS 11'h5DB
`define CIQ_GAP_MAX 11'h7FF
`define CIQ_GAP_W 11
`define CIQ_STARTUP_MS 7'h64
`define CIQ_START_W 7
`define CIQ_EVT_W 8

`endif

// File: pkg/ciq_pkg.sv
// Types shared by the control input qualifier.
// Assumes ciq_consts.svh is on the include path.
`include "ciq_consts.svh"

package ciq_pkg;

    // Raw control pins of one channel, both active low.
    typedef struct packed {
        logic enable_n;
        logic inhibit_n;
    } ciq_ctl_t;

    // Qualified view of one channel, active high.
    typedef struct packed {
        logic enable;
        logic inhibit;
    } ciq_qual_t;

    typedef enum logic [1:0] {
        CIQ_PWR_START,
        CIQ_PWR_RUN,
        CIQ_PWR_LOSS
    } ciq_pwr_state_t;

endpackage

// File: tb/ciq_asserts.sv
// Port checker for the control input qualifier: channel 0 and the supply.
// Assumes it is bound into ciq_top and shares its tick length.
`include "ciq_consts.svh"

module ciq_asserts #(
    parameter int TICK_CYCLES = `CIQ_TICK_CYCLES
) (
    input wire logic clk,
    input wire logic rstn,
    input wire ciq_pkg::ciq_ctl_t [`CIQ_NCH-1:0] ctl_in,
    input wire logic ac_ok,
    input wire ciq_pkg::ciq_qual_t [`CIQ_NCH-1:0] qual_out,
    input wire logic [`CIQ_NCH-1:0] de_active,
    input wire logic startup_busy,
    input wire logic restart_pulse,
    input wire logic [`CIQ_EVT_W-1:0] interruption_count
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [15:0] L13 = 16'(13 * TICK_CYCLES);
    localparam logic [15:0] L19 = 16'(19 * TICK_CYCLES);
    localparam logic [15:0] L22 = 16'(22 * TICK_CYCLES);
    localparam logic [15:0] L49 = 16'(49 * TICK_CYCLES);
    localparam logic [15:0] L136 = 16'(136 * TICK_CYCLES);
    localparam logic [15:0] L300 = 16'(300 * TICK_CYCLES);
    localparam logic [15:0] L1500 = 16'(1500 * TICK_CYCLES);
    logic [15:0] lo_r;
    logic [15:0] rise_r;
    logic [15:0] off_r;
    logic [15:0] on_r;
    logic [15:0] gap_r;

    function automatic logic [15:0] inc(input logic [15:0] v);
        return (v == 16'hFFFF) ? v : v + 16'h0001;
    endfunction

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    ////////////////////////////////////////////////////////////////////////////
    // Low run length of the channel 0 enable pin and time since the qualified enable last rose.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            lo_r <= 16'h0000;
            rise_r <= 16'hFFFF;
        end else begin
            lo_r <= ctl_in[0].enable_n ? 16'h0000 : inc(lo_r);
            rise_r <= $rose(qual_out[0].enable) ? 16'h0001 : inc(rise_r);
        end
    end

    // Loss length, restoration length, and the restoration before a loss.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            off_r <= 16'h0000;
            on_r <= 16'h0000;
            gap_r <= 16'h0000;
        end else begin
            off_r <= ac_ok ? 16'h0000 : inc(off_r);
            on_r <= ac_ok ? inc(on_r) : 16'h0000;
            gap_r <= (!ac_ok && off_r == 16'h0000) ? on_r : gap_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    sequence s_rst2;
        !rstn ##1 !rstn;
    endsequence
    sequence s_de_ready;
        qual_out[0].enable && !qual_out[0].inhibit && !startup_busy;
    endsequence
    sequence s_short_back;
        $rose(ac_ok) && !startup_busy && off_r < L19 && gap_r >= L300;
    endsequence
    sequence s_long_back;
        $rose(ac_ok) && !startup_busy && off_r >= L22;
    endsequence

    AST_RST: assert property (disable iff (1'b0) s_rst2 |=> qual_out == '0
        && de_active == '0 && startup_busy && !restart_pulse && interruption_count == 8'h00)
        else $error("outputs not at reset values");
    AST_PULSE: assert property ($rose(qual_out[0].enable) |-> $past(lo_r) >= L13)
        else $error("enable qualified after a short low level");
    AST_HOLD: assert property (lo_r == L136 |-> qual_out[0].enable)
        else $error("long low level not qualified");
    AST_LOCK: assert property ($rose(qual_out[0].enable) |-> rise_r >= L49)
        else $error("same-direction change inside the lockout");
    AST_DE_ON: assert property (s_de_ready ##1 s_de_ready |-> de_active[0])
        else $error("delay/extension not switched on");
    AST_DE_OFF: assert property (de_active[0] |-> qual_out[0].enable
        && !qual_out[0].inhibit) else $error("delay/extension on without cause");
    AST_START: assert property (startup_busy && $past(startup_busy) |-> de_active == '0)
        else $error("delay/extension on during start-up");
    AST_RIDE: assert property (s_short_back |-> !restart_pulse [*3])
        else $error("short loss forced a restart");
    AST_LONG: assert property (s_long_back |-> ##[0:3] restart_pulse)
        else $error("long loss did not restart");
    AST_PULSE1: assert property (restart_pulse |=> !restart_pulse && startup_busy)
        else $error("restart pulse malformed");
    AST_CNT_EDGE: assert property ($changed(interruption_count)
        |-> $past(ac_ok, 2) && !$past(ac_ok)) else $error("count moved without a loss");
    AST_CNT_INC: assert property ($fell(ac_ok) && on_r >= L1500
        && interruption_count != 8'hFF |=> interruption_count == $past(interruption_count) + 8'h01)
        else $error("separate interruption not counted");
endmodule

bind ciq_top ciq_asserts #(.TICK_CYCLES(TICK_CYCLES)) u_ciq_asserts (.clk(clk), .rstn(rstn),
    .ctl_in(ctl_in), .ac_ok(ac_ok), .qual_out(qual_out), .de_active(de_active),
    .startup_busy(startup_busy), .restart_pulse(restart_pulse),
    .interruption_count(interruption_count));

// File: tb/ciq_ctrl_model.sv
// Controller side of the control pins and of the AC supply.
// Assumes the bench sets levels and open pins off the rising edge.
module ciq_ctrl_model (
    input wire logic [7:0] pin_n,
    input wire logic [7:0] open_pin,
    input wire logic power_on,
    output ciq_pkg::ciq_ctl_t [3:0] ctl_in,
    output logic ac_ok
);
    timeunit 1ns;
    timeprecision 1ps;
    // An open pin is pulled up to the supply, so it reads as deasserted.
    assign ctl_in = pin_n | open_pin;
    assign ac_ok = power_on;
endmodule

// File: tb/tb.sv
// Self-checking bench for the control input qualifier with a short tick.
// Assumes ten clock cycles per millisecond tick.
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int TK = 10;
    typedef struct {int ch; int fld; int ms; logic exp;} ciq_row_t;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic power_on = 1'b1;
    logic [7:0] pin_n = 8'hFF;
    logic [7:0] open_pin = 8'h00;
    logic rp_seen = 1'b0;
    ciq_pkg::ciq_ctl_t [3:0] ctl_in;
    logic ac_ok;
    ciq_pkg::ciq_qual_t [3:0] qual_out;
    logic [3:0] de_active;
    logic startup_busy;
    logic restart_pulse;
    logic [7:0] interruption_count;
    int fail_count = 0;
    int cmp_count = 0;
    ciq_row_t rows [8] = '{'{0, 0, 5, 1'b0}, '{0, 0, 13, 1'b0}, '{0, 0, 31, 1'b1},
        '{1, 1, 31, 1'b1}, '{2, 0, 31, 1'b1}, '{3, 1, 13, 1'b0}, '{3, 0, 31, 1'b1},
        '{1, 0, 2, 1'b0}};

    always #2 clk = ~clk;
    always @(posedge clk) if (restart_pulse === 1'b1) rp_seen <= 1'b1;

    ciq_ctrl_model u_ctrl (.pin_n(pin_n), .open_pin(open_pin), .power_on(power_on),
        .ctl_in(ctl_in), .ac_ok(ac_ok));
    ciq_top #(.TICK_CYCLES(TK)) dut (.clk(clk), .rstn(rstn), .ctl_in(ctl_in), .ac_ok(ac_ok),
        .qual_out(qual_out), .de_active(de_active), .startup_busy(startup_busy),
        .restart_pulse(restart_pulse), .interruption_count(interruption_count));

    ////////////////////////////////////////////////////////////////////////////
    task automatic ms(input int n);
        repeat (n * TK) @(negedge clk);
    endtask

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("FAIL %0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic results();
        $display("compares %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (10) @(negedge clk);
        chk(8'(qual_out), 8'h00);
        chk(interruption_count, 8'h00);
        rstn = 1'b1;
        ms(90);
        chk(8'(startup_busy), 8'h01);
        for (int i = 0; i < 200 * TK && startup_busy !== 1'b0; i++) @(negedge clk);
        if (startup_busy !== 1'b0) begin
            fail_count++;
            results();
        end
        foreach (rows[i]) begin
            pin_n[2 * rows[i].ch + 1 - rows[i].fld] = 1'b0;
            ms(rows[i].ms);
            chk(8'(qual_out[rows[i].ch][1 - rows[i].fld]), 8'(rows[i].exp));
            chk(8'(de_active[rows[i].ch]), 8'(rows[i].exp && rows[i].fld == 0));
            pin_n = 8'hFF;
            ms(60);
        end
        // An open enable pin must never qualify.
        open_pin = 8'h20;
        pin_n = 8'hDF;
        ms(31);
        chk(8'(qual_out[2]), 8'h00);
        open_pin = 8'h00;
        pin_n = 8'hFF;
        // Enable and inhibit together: inhibit wins.
        pin_n = 8'hF3;
        ms(31);
        chk(8'(qual_out[1]), 8'h03);
        chk(8'(de_active[1]), 8'h00);
        pin_n = 8'hFF;
        ms(60);
        // Second rising change follows the first too closely and must wait.
        pin_n = 8'hFD;
        ms(20);
        pin_n = 8'hFF;
        ms(16);
        pin_n = 8'hFD;
        ms(16);
        chk(8'(qual_out[0].enable), 8'h00);
        ms(18);
        chk(8'(qual_out[0].enable), 8'h01);
        // Keep the pin low past 136 ms so the long-hold check is reached.
        ms(120);
        pin_n = 8'hFF;
        ms(800);
        power_on = 1'b0;
        ms(10);
        power_on = 1'b1;
        ms(1);
        chk(interruption_count, 8'h01);
        repeat (2) begin
            ms(400);
            power_on = 1'b0;
            ms(10);
            power_on = 1'b1;
        end
        ms(1);
        chk(8'(rp_seen), 8'h00);
        chk(8'(startup_busy), 8'h00);
        chk(interruption_count, 8'h01);
        ms(400);
        power_on = 1'b0;
        ms(30);
        power_on = 1'b1;
        ms(1);
        chk(8'(rp_seen), 8'h01);
        chk(8'(startup_busy), 8'h01);
        ms(1600);
        power_on = 1'b0;
        ms(5);
        power_on = 1'b1;
        ms(1);
        chk(interruption_count, 8'h02);
        results();
    end
endmodule
